// ---- rtl/azq_cfg.svh ----
`ifndef AZQ_CFG_SVH
`define AZQ_CFG_SVH

// ----------------------------------------
// Time base
// ----------------------------------------
`define AZQ_NS_PER_S 1000000000
`define AZQ_CLK_PERIOD_NS 25
`define AZQ_XZ_WINDOW_S 9'h12c
`define AZQ_SUP_UNIT_S 17'h01c20
`define AZQ_SUP_MIN 4'h2

// ----------------------------------------
// Zones, keys and macros
// ----------------------------------------
`define AZQ_ZONE_NONE 8'h00
`define AZQ_ZONE_MAX 8'hfa
`define AZQ_RX1_ZONE 10'h3de
`define AZQ_RX2_ZONE 10'h3dc
`define AZQ_KEY_PANIC 6'h00
`define AZQ_MACRO_MAX 6'h20
`define AZQ_KEY_CFG_W 6

// ----------------------------------------
// Report event codes (BCD digits)
// ----------------------------------------
`define AZQ_CID_XZ_ERR 12'h378
`define AZQ_CID_RX_SUP 12'h381
`define AZQ_CID_TX_SUP 12'h381
`define AZQ_CID_TX_LB 12'h384

`endif

// ---- rtl/azq_pkg.sv ----
package azq_pkg;
  typedef logic [7:0] azq_zone_t;
  typedef logic [9:0] azq_rep_id_t;
  typedef enum logic [1:0] {AZQ_KEY_A, AZQ_KEY_B, AZQ_KEY_C, AZQ_KEY_D} azq_key_t;
endpackage : azq_pkg

// ---- rtl/azq_sup_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "azq_cfg.svh"

module azq_sup_timer (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic tick_i,
  input wire logic checkin_i,
  input wire logic [3:0] interval_i,
  output logic fail_o,
  output logic fail_pulse_o
);
  typedef struct packed {
    logic [16:0] cnt;
    logic fail;
    logic pulse;
  } azq_sup_st_t;

  azq_sup_st_t s;
  azq_sup_st_t next_s;
  logic en;
  logic [16:0] limit;

  // Interval is counted in two-hour units; 00 and 01 leave supervision off
  assign en = interval_i >= `AZQ_SUP_MIN;
  assign limit = 17'(interval_i) * `AZQ_SUP_UNIT_S;

  always_comb begin
    next_s = s;
    next_s.pulse = 1'b0;
    if (!en || checkin_i) begin
      next_s.cnt = '0;
      next_s.fail = 1'b0;
    end else if (tick_i && !s.fail) begin
      if (17'(s.cnt + 17'h00001) >= limit) begin
        next_s.fail = 1'b1;
        next_s.pulse = 1'b1;
      end else begin
        next_s.cnt = 17'(s.cnt + 17'h00001);
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign fail_o = s.fail;
  assign fail_pulse_o = s.pulse;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_fail_needs_enable;
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(fail_o) |-> $past(interval_i) >= `AZQ_SUP_MIN && $past(s.cnt) == limit - 17'h00001;
  endproperty
  a_fail_needs_enable: assert property (p_fail_needs_enable) else $error("supervision fail early");
  property p_checkin_clears;
    @(posedge clk_i) disable iff (!resetn_i)
    checkin_i |=> !fail_o && s.cnt == '0;
  endproperty
  a_checkin_clears: assert property (p_checkin_clears) else $error("checkin did not clear");
  c_fail: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(fail_o));
endmodule : azq_sup_timer
`default_nettype wire

// ---- rtl/azq_qualifier.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "azq_cfg.svh"

// What this block does
// - Alarm needs both pair zones within five minutes
// - First zone still faulted when second trips
// - Four pairs, zones 1-250, zero disables pair
// - Bypassed or type-0 zone skips pair qualification
// - First zone of pair is processed first
// - Fault relay follows either zone alone
// - Alarm relay needs both; restore needs both
// - Partner timeout sends cross-zone error 378
// - Receiver silent interval raises zone 990/988
// - Silent transmitter raises trouble and report
// - Low-battery annunciation disarmed-only or always
// - Low-battery report optional; supervision always
// - Keys A-C panic or macro; D selectable
// - Global user authority overrides macro arming
module azq_qualifier #(
  parameter int ZONES = 250,
  parameter int NTX = 8,
  parameter int TICK_CYC = `AZQ_NS_PER_S / `AZQ_CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [ZONES-1:0] zone_fault_i,
  input wire logic [ZONES-1:0] zone_bypass_i,
  input wire logic [ZONES-1:0] zone_type0_i,
  input wire logic [31:0] pair_first_i,
  input wire logic [31:0] pair_second_i,
  input wire logic restore_mode_i,
  input wire logic relay_clear_i,
  output logic [3:0] xz_alarm_o,
  output logic [3:0] pair_skip_o,
  output logic [3:0] relay_fault_o,
  output logic [3:0] relay_alarm_o,
  input wire logic [1:0] rx_heard_i,
  input wire logic [3:0] rx_interval_i,
  output logic [1:0] rx_fail_o,
  input wire logic [NTX-1:0] tx_checkin_i,
  input wire logic [3:0] tx_interval_i,
  output logic [NTX-1:0] tx_fail_o,
  input wire logic [NTX-1:0] tx_lowbat_i,
  input wire logic armed_i,
  input wire logic lb_sound_both_i,
  input wire logic lb_report_en_i,
  output logic lb_annunciate_o,
  output logic rep_valid_o,
  input wire logic rep_ready_i,
  output logic [11:0] rep_code_o,
  output logic [9:0] rep_id_o,
  input wire logic key_press_i,
  input wire logic [1:0] key_sel_i,
  input wire logic [23:0] key_cfg_i,
  input wire logic [5:0] user_macro_i,
  input wire logic user_global_i,
  output logic panic_o,
  output logic macro_run_o,
  output logic [5:0] macro_num_o,
  output logic global_override_o
);
  typedef struct packed {
    logic [25:0] div;
    logic tick;
    logic [3:0] run;
    logic [3:0] first_b;
    logic [3:0] aq;
    logic [3:0] bq;
    logic [3:0] relay;
    logic [3:0] alarm;
    logic [3:0][8:0] tmr;
    logic [3:0] pend_xz;
    logic [1:0] pend_rx;
    logic [NTX-1:0] pend_ts;
    logic [NTX-1:0] pend_lb;
    logic [NTX-1:0] lbq;
    logic annun;
    logic rep_valid;
    logic [11:0] code;
    logic [9:0] id;
    logic panic;
    logic mrun;
    logic ovr;
    logic [5:0] mnum;
  } azq_st_t;

  azq_st_t s;
  azq_st_t next_s;
  logic [3:0] fa;
  logic [3:0] fb;
  logic [3:0] act;
  logic [1:0] rx_pulse;
  logic [NTX-1:0] tx_pulse;

  function automatic logic zsel(input logic [ZONES-1:0] v, input azq_pkg::azq_zone_t z);
    zsel = 1'b0;
    if (z != `AZQ_ZONE_NONE && z <= `AZQ_ZONE_MAX) begin
      zsel = v[z - 8'h01];
    end
  endfunction : zsel

  function automatic logic macro_ok(input logic [5:0] m);
    macro_ok = m != `AZQ_KEY_PANIC && m <= `AZQ_MACRO_MAX;
  endfunction : macro_ok

  // ----------------------------------------
  // Pair decode
  // ----------------------------------------
  for (genvar p = 0; p < 4; p++) begin : g_pair
    azq_pkg::azq_zone_t za;
    azq_pkg::azq_zone_t zb;
    logic en;
    assign za = pair_first_i[p*8 +: 8];
    assign zb = pair_second_i[p*8 +: 8];
    // A zone number outside 1-250 counts as none, so half a pair never runs
    assign en = za != `AZQ_ZONE_NONE && za <= `AZQ_ZONE_MAX
        && zb != `AZQ_ZONE_NONE && zb <= `AZQ_ZONE_MAX;
    assign pair_skip_o[p] = en && (zsel(zone_bypass_i, za) || zsel(zone_bypass_i, zb)
        || zsel(zone_type0_i, za) || zsel(zone_type0_i, zb));
    assign act[p] = en && !pair_skip_o[p];
    assign fa[p] = zsel(zone_fault_i, za);
    assign fb[p] = zsel(zone_fault_i, zb);
    assign relay_fault_o[p] = act[p] && (fa[p] || fb[p]);
  end

  // ----------------------------------------
  // Supervision timers
  // ----------------------------------------
  for (genvar r = 0; r < 2; r++) begin : g_rx
    azq_sup_timer u_rx (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .tick_i(s.tick),
      .checkin_i(rx_heard_i[r]),
      .interval_i(rx_interval_i),
      .fail_o(rx_fail_o[r]),
      .fail_pulse_o(rx_pulse[r])
    );
  end
  for (genvar t = 0; t < NTX; t++) begin : g_tx
    azq_sup_timer u_tx (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .tick_i(s.tick),
      .checkin_i(tx_checkin_i[t]),
      .interval_i(tx_interval_i),
      .fail_o(tx_fail_o[t]),
      .fail_pulse_o(tx_pulse[t])
    );
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [3:0] set_xz;
    logic [NTX-1:0] set_lb;
    logic found;
    logic [5:0] kc;
    logic rise_a;
    logic rise_b;
    next_s = s;
    set_xz = '0;
    set_lb = '0;
    found = 1'b0;
    kc = key_cfg_i[key_sel_i*`AZQ_KEY_CFG_W +: `AZQ_KEY_CFG_W];
    rise_a = 1'b0;
    rise_b = 1'b0;
    next_s.tick = 1'b0;
    next_s.alarm = '0;
    if (s.div == 26'(TICK_CYC - 1)) begin
      next_s.div = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = 26'(s.div + 26'h0000001);
    end
    for (int p = 0; p < 4; p++) begin
      rise_a = fa[p] && !s.aq[p];
      rise_b = fb[p] && !s.bq[p];
      next_s.aq[p] = fa[p];
      next_s.bq[p] = fb[p];
      if (!act[p]) begin
        next_s.run[p] = 1'b0;
        next_s.relay[p] = 1'b0;
      end else begin
        // Simultaneous trips count as the first zone followed by the second
        if ((rise_b && fa[p] && (s.run[p] || rise_a))
            || (rise_a && fb[p] && s.run[p])) begin
          next_s.run[p] = 1'b0;
          next_s.alarm[p] = 1'b1;
          next_s.relay[p] = 1'b1;
        end else if (s.run[p] && s.tick && s.tmr[p] == 9'(`AZQ_XZ_WINDOW_S - 9'h001)) begin
          next_s.run[p] = 1'b0;
          set_xz[p] = 1'b1;
        end else if (s.run[p] && s.tick) begin
          next_s.tmr[p] = 9'(s.tmr[p] + 9'h001);
        end else if (!s.run[p] && (rise_a || rise_b)) begin
          next_s.run[p] = 1'b1;
          next_s.first_b[p] = rise_b && !rise_a;
          next_s.tmr[p] = '0;
        end
        // A new alarm in the same cycle as a clear keeps the relay set
        if (s.relay[p] && !next_s.alarm[p]
            && ((restore_mode_i && !fa[p] && !fb[p]) || relay_clear_i)) begin
          next_s.relay[p] = 1'b0;
        end
      end
    end
    for (int t = 0; t < NTX; t++) begin
      set_lb[t] = tx_lowbat_i[t] && !s.lbq[t] && lb_report_en_i;
    end
    next_s.lbq = tx_lowbat_i;
    next_s.annun = (|tx_lowbat_i) && (!armed_i || lb_sound_both_i);
    // Report queue: one event per handshake, cross-zone errors first
    if (!s.rep_valid || rep_ready_i) begin
      next_s.rep_valid = 1'b0;
      for (int p = 0; p < 4; p++) begin
        if (!found && s.pend_xz[p]) begin
          found = 1'b1;
          next_s.pend_xz[p] = 1'b0;
          next_s.code = `AZQ_CID_XZ_ERR;
          next_s.id = {2'h0, s.first_b[p] ? pair_second_i[p*8 +: 8] : pair_first_i[p*8 +: 8]};
        end
      end
      for (int r = 0; r < 2; r++) begin
        if (!found && s.pend_rx[r]) begin
          found = 1'b1;
          next_s.pend_rx[r] = 1'b0;
          next_s.code = `AZQ_CID_RX_SUP;
          next_s.id = (r == 0) ? `AZQ_RX1_ZONE : `AZQ_RX2_ZONE;
        end
      end
      for (int t = 0; t < NTX; t++) begin
        if (!found && s.pend_ts[t]) begin
          found = 1'b1;
          next_s.pend_ts[t] = 1'b0;
          next_s.code = `AZQ_CID_TX_SUP;
          next_s.id = 10'(t + 1);
        end else if (!found && s.pend_lb[t]) begin
          found = 1'b1;
          next_s.pend_lb[t] = 1'b0;
          next_s.code = `AZQ_CID_TX_LB;
          next_s.id = 10'(t + 1);
        end
      end
      next_s.rep_valid = found;
    end
    // Sets are merged after the pick so a same-cycle event is never lost
    next_s.pend_xz = next_s.pend_xz | set_xz;
    next_s.pend_rx = next_s.pend_rx | rx_pulse;
    next_s.pend_ts = next_s.pend_ts | tx_pulse;
    next_s.pend_lb = next_s.pend_lb | set_lb;
    next_s.panic = 1'b0;
    next_s.mrun = 1'b0;
    if (key_press_i) begin
      if (key_sel_i != azq_pkg::AZQ_KEY_D && kc == `AZQ_KEY_PANIC) begin
        next_s.panic = 1'b1;
      end else if (macro_ok(kc)) begin
        next_s.mrun = 1'b1;
        next_s.mnum = kc;
        next_s.ovr = user_global_i;
      end else if (key_sel_i == azq_pkg::AZQ_KEY_D && kc == `AZQ_KEY_PANIC
                   && macro_ok(user_macro_i)) begin
        next_s.mrun = 1'b1;
        next_s.mnum = user_macro_i;
        next_s.ovr = user_global_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign xz_alarm_o = s.alarm;
  assign relay_alarm_o = s.relay;
  assign lb_annunciate_o = s.annun;
  assign rep_valid_o = s.rep_valid;
  assign rep_code_o = s.code;
  assign rep_id_o = s.id;
  assign panic_o = s.panic;
  assign macro_run_o = s.mrun;
  assign macro_num_o = s.mnum;
  assign global_override_o = s.ovr;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_alarm_both;
    @(posedge clk_i) disable iff (!resetn_i)
    xz_alarm_o[0] |-> $past(fa[0] && fb[0] && act[0]);
  endproperty
  a_alarm_both: assert property (p_alarm_both) else $error("alarm without both zones");
  property p_skip_blocks;
    @(posedge clk_i) disable iff (!resetn_i)
    pair_skip_o[0] |=> !xz_alarm_o[0] && !relay_alarm_o[0];
  endproperty
  a_skip_blocks: assert property (p_skip_blocks) else $error("skipped pair qualified");
  property p_relay_rise;
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(relay_alarm_o[0]) |-> xz_alarm_o[0];
  endproperty
  a_relay_rise: assert property (p_relay_rise) else $error("relay without alarm");
  property p_relay_hold;
    @(posedge clk_i) disable iff (!resetn_i)
    $fell(relay_alarm_o[0]) |-> $past(!act[0] || relay_clear_i
        || (restore_mode_i && !fa[0] && !fb[0]));
  endproperty
  a_relay_hold: assert property (p_relay_hold) else $error("relay released early");
  property p_rep_stable;
    @(posedge clk_i) disable iff (!resetn_i)
    rep_valid_o && !rep_ready_i |=> rep_valid_o && $stable(rep_code_o) && $stable(rep_id_o);
  endproperty
  a_rep_stable: assert property (p_rep_stable) else $error("report changed while stalled");
  property p_annun;
    @(posedge clk_i) disable iff (!resetn_i)
    lb_annunciate_o |-> $past(!armed_i || lb_sound_both_i);
  endproperty
  a_annun: assert property (p_annun) else $error("low battery shown while armed");
  property p_panic;
    @(posedge clk_i) disable iff (!resetn_i)
    key_press_i && key_sel_i == azq_pkg::AZQ_KEY_A && key_cfg_i[5:0] == `AZQ_KEY_PANIC
    |=> panic_o && !macro_run_o;
  endproperty
  a_panic: assert property (p_panic) else $error("key A panic missing");
  property p_override;
    @(posedge clk_i) disable iff (!resetn_i)
    key_press_i && user_global_i && macro_ok(key_cfg_i[11:6]) && key_sel_i == azq_pkg::AZQ_KEY_B
    |=> macro_run_o && global_override_o && macro_num_o == $past(key_cfg_i[11:6]);
  endproperty
  a_override: assert property (p_override) else $error("global authority lost");
  c_alarm: cover property (@(posedge clk_i) disable iff (!resetn_i) xz_alarm_o[0]);
  c_xz_err: cover property (@(posedge clk_i) disable iff (!resetn_i)
      rep_valid_o && rep_code_o == `AZQ_CID_XZ_ERR);
  c_macro: cover property (@(posedge clk_i) disable iff (!resetn_i) macro_run_o);
endmodule : azq_qualifier
`default_nettype wire

// ---- tb/azq_reporter.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Central-station reporter model
// ----------------------------------------
module azq_reporter (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] stall_i,
  input wire logic rep_valid_i,
  input wire logic [11:0] rep_code_i,
  input wire logic [9:0] rep_id_i,
  output logic rep_ready_o,
  output logic got_o,
  output logic [21:0] got_data_o
);
  logic [3:0] cnt;

  // Ready waits stall_i cycles so that the report must hold until taken
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rep_ready_o <= 1'b0;
      got_o <= 1'b0;
      got_data_o <= 22'h0;
      cnt <= 4'h0;
    end else begin
      got_o <= 1'b0;
      if (rep_valid_i && rep_ready_o) begin
        got_o <= 1'b1;
        got_data_o <= {rep_code_i, rep_id_i};
        rep_ready_o <= 1'b0;
        cnt <= 4'h0;
      end else if (rep_valid_i) begin
        if (cnt >= stall_i) begin
          rep_ready_o <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule : azq_reporter

`default_nettype wire

// ---- tb/test_azq_qualifier.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_azq_qualifier;
  // Short tick keeps the two-hour supervision unit inside the run
  localparam int TK = 2;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [249:0] flt = '0, byp = '0, t0 = '0;
  logic [31:0] pf = 32'h00fb0301, ps = 32'h00040002;
  logic rmode = 1'b1, armed = 1'b0, lbb = 1'b0, lbr = 1'b0, kp = 1'b0, ug = 1'b0;
  logic rclr = 1'b0;
  logic [3:0] sint = 4'h2;
  logic [1:0] rxh = '0, txc = '0, lb = '0, ks = '0;
  logic [3:0] stall = 4'h0, xza, skip, rf, ra;
  logic [23:0] kc = '0;
  logic [5:0] um = '0, mnum;
  logic [1:0] rxf, txf;
  logic lba, rv, rdy, pnc, mrun, gov, got;
  logic [11:0] rc;
  logic [9:0] rid;
  logic [21:0] gd;
  logic [21:0] q[$];
  int fail_count = 0;
  int checks_done = 0;
  int na = 0;

  always #12.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (xza[0] === 1'b1) na <= na + 1;
    if (got === 1'b1) q.push_back(gd);
  end

  azq_qualifier #(.ZONES(250), .NTX(2), .TICK_CYC(TK)) azq_qualifier_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .zone_fault_i(flt), .zone_bypass_i(byp),
    .zone_type0_i(t0), .pair_first_i(pf), .pair_second_i(ps), .restore_mode_i(rmode),
    .relay_clear_i(rclr), .xz_alarm_o(xza), .pair_skip_o(skip), .relay_fault_o(rf),
    .relay_alarm_o(ra), .rx_heard_i(rxh), .rx_interval_i(sint), .rx_fail_o(rxf),
    .tx_checkin_i(txc), .tx_interval_i(sint), .tx_fail_o(txf), .tx_lowbat_i(lb),
    .armed_i(armed), .lb_sound_both_i(lbb), .lb_report_en_i(lbr), .lb_annunciate_o(lba),
    .rep_valid_o(rv), .rep_ready_i(rdy), .rep_code_o(rc), .rep_id_o(rid),
    .key_press_i(kp), .key_sel_i(ks), .key_cfg_i(kc), .user_macro_i(um),
    .user_global_i(ug), .panic_o(pnc), .macro_run_o(mrun), .macro_num_o(mnum),
    .global_override_o(gov));

  azq_reporter azq_reporter_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .stall_i(stall), .rep_valid_i(rv),
    .rep_code_i(rc), .rep_id_i(rid), .rep_ready_o(rdy), .got_o(got), .got_data_o(gd));

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task zone(input int z, input logic v);
    @(posedge clk_i);
    flt[z-1] <= v;
  endtask : zone

  task key(input logic [1:0] s, input logic [5:0] c, input logic [5:0] u, input logic g,
           input logic [7:0] e);
    @(posedge clk_i);
    kp <= 1'b1;
    ks <= s;
    kc[6*s+:6] <= c;
    um <= u;
    ug <= g;
    @(posedge clk_i);
    kp <= 1'b0;
    #1;
    chk("key", e, {pnc, mrun, mnum});
  endtask : key

  task rep(input logic [11:0] c, input logic [9:0] i, input logic ci, input int w);
    logic [21:0] d;
    int k;
    k = 0;
    while (q.size() == 0 && k < w) begin
      cyc(1);
      k++;
    end
    d = (q.size() > 0) ? q.pop_front() : 22'h3fffff;
    chk("rep_code", c, d[21:10]);
    if (ci) chk("rep_id", i, d[9:0]);
  endtask : rep

  task quiet(input int n);
    cyc(n);
    chk("rep_none", 0, q.size());
  endtask : quiet

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    cyc(2);
    key(2'h0, 6'h00, 6'h00, 1'b0, 8'h80);
    key(2'h1, 6'h05, 6'h00, 1'b0, 8'h45);
    key(2'h3, 6'h00, 6'h07, 1'b0, 8'h47);
    chk("global", 0, gov);
    key(2'h3, 6'h00, 6'h07, 1'b1, 8'h47);
    chk("global", 1, gov);
    key(2'h3, 6'h20, 6'h00, 1'b0, 8'h60);
    key(2'h2, 6'h21, 6'h00, 1'b0, 8'h20);
    key(2'h1, 6'h05, 6'h00, 1'b1, 8'h45);
    chk("global", 1, gov);
    key(2'h3, 6'h00, 6'h00, 1'b0, 8'h05);
    $display("test keys done");
    zone(1, 1'b1);
    cyc(2);
    chk("relay_fault", 4'h1, rf);
    chk("relay_alarm", 0, ra);
    zone(2, 1'b1);
    cyc(3);
    chk("alarms", 1, na);
    chk("relay_alarm", 4'h1, ra);
    zone(1, 1'b0);
    cyc(3);
    chk("relay_alarm", 4'h1, ra);
    zone(2, 1'b0);
    cyc(3);
    chk("relay_alarm", 0, ra);
    rmode <= 1'b0;
    zone(1, 1'b1);
    zone(2, 1'b1);
    zone(1, 1'b0);
    zone(2, 1'b0);
    cyc(3);
    chk("relay_alarm", 4'h1, ra);
    rclr <= 1'b1;
    cyc(1);
    rclr <= 1'b0;
    cyc(2);
    chk("relay_alarm", 0, ra);
    chk("alarms", 2, na);
    quiet(700);
    $display("test coincidence done");
    zone(1, 1'b1);
    cyc(3);
    zone(1, 1'b0);
    cyc(3);
    zone(2, 1'b1);
    cyc(3);
    zone(2, 1'b0);
    quiet(540);
    rep(12'h378, 10'h001, 1'b1, 200);
    chk("alarms", 2, na);
    $display("test momentary done");
    zone(3, 1'b1);
    zone(4, 1'b1);
    cyc(2);
    chk("inactive", 0, {skip, rf[3:1]});
    zone(3, 1'b0);
    zone(4, 1'b0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      byp[1] <= (i == 0);
      t0[0] <= (i == 1);
      cyc(2);
      chk("skip", 4'h1, skip);
      zone(1, 1'b1);
      zone(2, 1'b1);
      cyc(3);
      chk("alarms", 2, na);
      zone(1, 1'b0);
      zone(2, 1'b0);
    end
    $display("test skip done");
    @(posedge clk_i);
    armed <= 1'b1;
    lb[0] <= 1'b1;
    cyc(3);
    chk("lb_sound", 0, lba);
    lbb <= 1'b1;
    cyc(3);
    chk("lb_sound", 1, lba);
    armed <= 1'b0;
    lbb <= 1'b0;
    cyc(3);
    chk("lb_sound", 1, lba);
    quiet(20);
    lb[0] <= 1'b0;
    lbr <= 1'b1;
    cyc(3);
    lb[0] <= 1'b1;
    rep(12'h384, 10'h001, 1'b1, 50);
    $display("test low battery done");
    stall <= 4'h3;
    while ($time < 625000) cyc(1);
    chk("silent", 0, {rxf, txf});
    rep(12'h381, 10'h3dc, 1'b1, 6000);
    rep(12'h381, 10'h001, 1'b1, 100);
    chk("rx_fail", 2'h2, rxf);
    chk("tx_fail", 2'h1, txf);
    sint <= 4'h0;
    cyc(2);
    chk("sup_off", 0, {rxf, txf});
    $display("test supervision done");
    final_report();
  end

  // First receiver and second transmitter keep checking in
  initial begin
    forever begin
      cyc(8000);
      rxh <= 2'h1;
      txc <= 2'h2;
      @(posedge clk_i);
      rxh <= 2'h0;
      txc <= 2'h0;
    end
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    $display("ERROR watchdog expected done seen timeout");
    final_report();
  end
endmodule : test_azq_qualifier

`default_nettype wire
